// ==== rtl/rbs_pkg.sv ====
// Shared constants and types for the reset and boot sequencer.
`default_nettype none
package rbs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int ROM_ACCESS_NS = 40;
  localparam int ROM_ACCESS_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Boot copy and start address
  // ----------------------------------------
  localparam int COPY_BYTES = 1024;
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
  localparam logic [31:0] ROM_BASE_RST = 32'h0000_0000;

  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [4:0] OFF_HPC = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_ROM_BASE = 5'h08;
  localparam logic [4:0] OFF_MEM_ADDR = 5'h0C;
  localparam logic [4:0] OFF_MEM_DATA = 5'h10;
  localparam int HPC_HINT_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_STALL_BIT = 2;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_PCI_BIT = 5;
  localparam int ST_EMU_BIT = 6;
  localparam int ST_EMU_LAT_BIT = 7;
  localparam int ST_BUSY_BIT = 8;
  localparam logic HINT_RST = 1'h0;
  localparam logic EMU_RST = 1'h0;
  localparam logic [1:0] EMU_SEL_BOUNDARY_SCAN_LOGIC = 2'h0;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    BOOT_NONE = 2'b00,
    BOOT_HOST = 2'b01,
    BOOT_ROM = 2'b10
  } rbs_boot_e;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOST_STALL = 2'b01,
    ST_ROM_COPY = 2'b10,
    ST_RUN = 2'b11
  } rbs_state_e;

endpackage

`default_nettype wire

// ==== rtl/rbs_rom_copier.sv ====
// Boot copy engine: reads ROM bytes and writes packed 32-bit words.
`timescale 1ns/1ps
`default_nettype none

module rbs_rom_copier #(
  parameter int COPY_BYTES = rbs_pkg::COPY_BYTES,
  parameter int ACCESS_CYC = rbs_pkg::ROM_ACCESS_CYC,
  parameter int IDX_W = $clog2(COPY_BYTES / 4)
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [31:0] base_i,
  input wire logic big_endian_i,
  input wire logic [7:0] rom_data_i,
  output logic rom_rd_o,
  output logic [31:0] rom_addr_o,
  output logic wr_o,
  output logic [IDX_W-1:0] wr_idx_o,
  output logic [31:0] wr_data_o,
  output logic busy_o,
  output logic done_o
);

  localparam int BW = $clog2(COPY_BYTES);
  localparam int WW = $clog2(ACCESS_CYC + 1);
  localparam logic [BW-1:0] LAST = BW'(COPY_BYTES - 1);
  localparam logic [WW-1:0] WAIT_LOAD = WW'(ACCESS_CYC - 1);

  if (COPY_BYTES < 8 || COPY_BYTES % 4 != 0 || ACCESS_CYC < 1)
  begin : g_check
    $error("Copy length must be whole words and the access time at least one cycle.");
  end

  logic [BW-1:0] cnt_reg, cnt_next;
  logic [WW-1:0] wait_reg, wait_next;
  logic [31:0] word_reg, word_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [IDX_W-1:0] widx_reg, widx_next;
  logic busy_reg, busy_next;
  logic wr_reg, wr_next;
  logic done_reg, done_next;

  // ----------------------------------------
  // Copy sequencing
  // ----------------------------------------
  // One unbroken pass over the whole block; each byte holds the strobe for the access time.
  always_comb
  begin
    cnt_next = cnt_reg;
    wait_next = wait_reg;
    word_next = word_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    widx_next = widx_reg;
    busy_next = busy_reg;
    wr_next = 1'b0;
    done_next = 1'b0;
    if (busy_reg)
    begin
      if (wait_reg != '0)
      begin
        wait_next = wait_reg - 1'b1;
      end
      else
      begin
        // Bytes are packed in the system byte order.
        if (big_endian_i)
        begin
          word_next = {word_reg[23:0], rom_data_i};
        end
        else
        begin
          word_next = {rom_data_i, word_reg[31:8]};
        end
        wr_next = (cnt_reg[1:0] == 2'h3);
        widx_next = IDX_W'(cnt_reg[BW-1:2]);
        wdata_next = word_next;
        if (cnt_reg == LAST)
        begin
          busy_next = 1'b0;
          done_next = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg + 1'b1;
          addr_next = addr_reg + 32'h0000_0001;
          wait_next = WAIT_LOAD;
        end
      end
    end
    else if (start_i)
    begin
      busy_next = 1'b1;
      cnt_next = '0;
      addr_next = base_i;
      wait_next = WAIT_LOAD;
    end
  end

  // Registers of the copy engine.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      wait_reg <= '0;
      word_reg <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      widx_reg <= '0;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
      word_reg <= word_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      widx_reg <= widx_next;
      busy_reg <= busy_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
    end
  end

  assign rom_rd_o = busy_reg;
  assign rom_addr_o = addr_reg;
  assign wr_o = wr_reg;
  assign wr_idx_o = widx_reg;
  assign wr_data_o = wdata_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;

  // The block ends with the write of its last word.
  AST_COPY_END: assert property (@(posedge core_clk_i) disable iff (rst_i)
    done_o |-> wr_o && wr_idx_o == IDX_W'(COPY_BYTES / 4 - 1) && !busy_o)
    else $error("Copy ended without writing the last word.");

endmodule

`default_nettype wire

// ==== rtl/rbs_sequencer.sv ====
// Reset and boot sequencer top: boot control, host flag, test reset and register slave.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Functional notes
// - Held in reset while reset input low.
// - Exactly three boot modes: host, ROM, none.
// - Host boot stalls core, releases the rest.
// - Strap picks host port or PCI path.
// - Host flag set releases core at zero.
// - Flag during stall never pends core interrupt.
// - Flag releases stall only in host boot.
// - Host may write and read back memory.
// - Flag blocks new ones until core clears.
// - ROM boot copies first 1 KB while stalled.
// - Bytes packed into words in system order.
// - One block copy, then core runs from zero.
// - No boot runs from zero at once.
// - Boot needs only device reset released.
// - Variant field valid only after reset release.
// - Test reset rise latches debug mode select; here only while the device is out of reset.
// - Latched select picks scan or emulation.
// ----------------------------------------

module rbs_sequencer #(
  parameter int MEM_WORDS = 256,
  parameter int COPY_BYTES = rbs_pkg::COPY_BYTES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic dev_reset_n_i,
  input wire logic [1:0] boot_mode_i,
  input wire logic pci_boot_sel_i,
  input wire logic big_endian_i,
  input wire logic test_reset_n_i,
  input wire logic [1:0] debug_mode_select_i,
  input wire logic core_hint_clr_i,
  input wire logic [$clog2(MEM_WORDS)-1:0] core_fetch_addr_i,
  output logic [31:0] core_fetch_data_o,
  output logic core_stall_o,
  output logic core_start_o,
  output logic [31:0] core_start_addr_o,
  output logic core_irq_o,
  output logic periph_reset_o,
  output logic host_port_en_o,
  output logic host_pci_en_o,
  output logic test_logic_reset_o,
  output logic emu_mode_o,
  output logic variant_valid_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic rom_rd_o,
  output logic [31:0] rom_addr_o,
  input wire logic [7:0] rom_data_i
);

  localparam int AW = $clog2(MEM_WORDS);
  localparam int CW = $clog2(COPY_BYTES / 4);

  if (MEM_WORDS < 2 || COPY_BYTES / 4 > MEM_WORDS)
  begin : g_check
    $error("Memory must hold the whole boot copy.");
  end

  logic [31:0] mem [MEM_WORDS];

  rbs_pkg::rbs_state_e state_reg, state_next;
  rbs_pkg::rbs_boot_e mode_reg, mode_next;
  logic pci_reg, pci_next;
  logic big_reg, big_next;
  logic stall_reg, stall_next;
  logic periph_reg, periph_next;
  logic start_reg, start_next;
  logic [31:0] start_addr_reg, start_addr_next;
  logic hpi_reg, hpi_next;
  logic pcien_reg, pcien_next;
  logic variant_reg, variant_next;
  logic copy_go_reg, copy_go_next;
  logic hint_reg, hint_next;
  logic irq_reg, irq_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] rom_base_reg, rom_base_next;
  logic [AW-1:0] maddr_reg, maddr_next;
  logic tst_prev_reg, tst_prev_next;
  logic emu_reg, emu_next;
  logic emu_lat_reg, emu_lat_next;
  logic tlr_reg, tlr_next;
  logic [31:0] fetch_reg, fetch_next;
  logic acc;
  logic wr_acc;
  logic hint_set;
  logic test_rise;
  logic mem_we;
  logic [AW-1:0] mem_widx;
  logic [31:0] mem_wdata;
  logic copy_wr;
  logic [CW-1:0] copy_idx;
  logic [31:0] copy_data;
  logic copy_busy;
  logic copy_done;

  // ----------------------------------------
  // Boot copy engine
  // ----------------------------------------
  rbs_rom_copier #(
    .COPY_BYTES(COPY_BYTES),
    .ACCESS_CYC(rbs_pkg::ROM_ACCESS_CYC),
    .IDX_W(CW)
  ) u_copier (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(copy_go_reg),
    .base_i(rom_base_reg),
    .big_endian_i(big_reg),
    .rom_data_i(rom_data_i),
    .rom_rd_o(rom_rd_o),
    .rom_addr_o(rom_addr_o),
    .wr_o(copy_wr),
    .wr_idx_o(copy_idx),
    .wr_data_o(copy_data),
    .busy_o(copy_busy),
    .done_o(copy_done)
  );

  // Bus request decode; the effect happens once, on the edge that sees waitrequest high.
  assign acc = (avs_read_i || avs_write_i) && wait_reg;
  assign wr_acc = avs_write_i && wait_reg;
  assign hint_set = wr_acc && avs_address_i == rbs_pkg::OFF_HPC
    && avs_writedata_i[rbs_pkg::HPC_HINT_BIT] && !hint_reg && dev_reset_n_i;
  assign test_rise = test_reset_n_i && !tst_prev_reg;

  // ----------------------------------------
  // Boot state machine
  // ----------------------------------------
  // Straps are taken while reset is low and frozen once it is released.
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    pci_next = pci_reg;
    big_next = big_reg;
    start_next = 1'b0;
    copy_go_next = 1'b0;
    if (!dev_reset_n_i)
    begin
      state_next = rbs_pkg::ST_RESET;
      pci_next = pci_boot_sel_i;
      big_next = big_endian_i;
      if (boot_mode_i == 2'h3)
      begin
        mode_next = rbs_pkg::BOOT_NONE;
      end
      else
      begin
        mode_next = rbs_pkg::rbs_boot_e'(boot_mode_i);
      end
    end
    else
    begin
      unique case (state_reg)
        rbs_pkg::ST_RESET:
        begin
          unique case (mode_reg)
            rbs_pkg::BOOT_HOST:
            begin
              state_next = rbs_pkg::ST_HOST_STALL;
            end
            rbs_pkg::BOOT_ROM:
            begin
              state_next = rbs_pkg::ST_ROM_COPY;
              copy_go_next = 1'b1;
            end
            default:
            begin
              state_next = rbs_pkg::ST_RUN;
              start_next = 1'b1;
            end
          endcase
        end
        rbs_pkg::ST_HOST_STALL:
        begin
          if (hint_set)
          begin
            state_next = rbs_pkg::ST_RUN;
            start_next = 1'b1;
          end
        end
        rbs_pkg::ST_ROM_COPY:
        begin
          if (copy_done)
          begin
            state_next = rbs_pkg::ST_RUN;
            start_next = 1'b1;
          end
        end
        rbs_pkg::ST_RUN:
        begin
          state_next = rbs_pkg::ST_RUN;
        end
      endcase
    end
    stall_next = state_next != rbs_pkg::ST_RUN;
    periph_next = state_next == rbs_pkg::ST_RESET;
    start_addr_next = start_next ? rbs_pkg::BOOT_ADDR : start_addr_reg;
    hpi_next = !periph_next && mode_next == rbs_pkg::BOOT_HOST && !pci_next;
    pcien_next = !periph_next && mode_next == rbs_pkg::BOOT_HOST && pci_next;
    variant_next = !periph_next;
  end

  // Registers of the boot state machine.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= rbs_pkg::ST_RESET;
      mode_reg <= rbs_pkg::BOOT_NONE;
      pci_reg <= 1'b0;
      big_reg <= 1'b0;
      stall_reg <= 1'b1;
      periph_reg <= 1'b1;
      start_reg <= 1'b0;
      start_addr_reg <= rbs_pkg::BOOT_ADDR;
      hpi_reg <= 1'b0;
      pcien_reg <= 1'b0;
      variant_reg <= 1'b0;
      copy_go_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      pci_reg <= pci_next;
      big_reg <= big_next;
      stall_reg <= stall_next;
      periph_reg <= periph_next;
      start_reg <= start_next;
      start_addr_reg <= start_addr_next;
      hpi_reg <= hpi_next;
      pcien_reg <= pcien_next;
      variant_reg <= variant_next;
      copy_go_reg <= copy_go_next;
    end
  end

  // ----------------------------------------
  // Host-to-core flag and register slave
  // ----------------------------------------
  // A stalled core never sees the flag as an interrupt; the set wins over a clear.
  always_comb
  begin
    hint_next = (hint_set || (hint_reg && !core_hint_clr_i)) && dev_reset_n_i;
    irq_next = hint_set && state_reg == rbs_pkg::ST_RUN;
    wait_next = !acc;
    rdata_next = rdata_reg;
    rom_base_next = rom_base_reg;
    maddr_next = maddr_reg;
    if (acc && avs_read_i)
    begin
      rdata_next = 32'h0000_0000;
      case (avs_address_i)
        rbs_pkg::OFF_HPC: rdata_next[rbs_pkg::HPC_HINT_BIT] = hint_reg;
        rbs_pkg::OFF_STATUS:
        begin
          rdata_next[rbs_pkg::ST_STATE_LSB +: 2] = state_reg;
          rdata_next[rbs_pkg::ST_STALL_BIT] = stall_reg;
          rdata_next[rbs_pkg::ST_MODE_LSB +: 2] = mode_reg;
          rdata_next[rbs_pkg::ST_PCI_BIT] = pci_reg;
          rdata_next[rbs_pkg::ST_EMU_BIT] = emu_reg;
          rdata_next[rbs_pkg::ST_EMU_LAT_BIT] = emu_lat_reg;
          rdata_next[rbs_pkg::ST_BUSY_BIT] = copy_busy;
        end
        rbs_pkg::OFF_ROM_BASE: rdata_next = rom_base_reg;
        rbs_pkg::OFF_MEM_ADDR: rdata_next[AW-1:0] = maddr_reg;
        rbs_pkg::OFF_MEM_DATA: rdata_next = mem[maddr_reg];
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_acc && avs_address_i == rbs_pkg::OFF_ROM_BASE)
    begin
      rom_base_next = avs_writedata_i;
    end
    if (wr_acc && avs_address_i == rbs_pkg::OFF_MEM_ADDR)
    begin
      maddr_next = avs_writedata_i[AW-1:0];
    end
  end

  // Registers of the flag and the slave.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hint_reg <= rbs_pkg::HINT_RST;
      irq_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      rom_base_reg <= rbs_pkg::ROM_BASE_RST;
      maddr_reg <= '0;
    end
    else
    begin
      hint_reg <= hint_next;
      irq_reg <= irq_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      rom_base_reg <= rom_base_next;
      maddr_reg <= maddr_next;
    end
  end

  // ----------------------------------------
  // Memory and test reset logic
  // ----------------------------------------
  // The copy owns the memory while busy; host writes then are dropped.
  always_comb
  begin
    mem_we = copy_wr || (wr_acc && avs_address_i == rbs_pkg::OFF_MEM_DATA && !copy_busy);
    mem_widx = copy_wr ? AW'(copy_idx) : maddr_reg;
    mem_wdata = copy_wr ? copy_data : avs_writedata_i;
    fetch_next = mem[core_fetch_addr_i];
    tst_prev_next = test_reset_n_i;
    tlr_next = !test_reset_n_i;
    emu_next = emu_reg;
    emu_lat_next = emu_lat_reg && dev_reset_n_i;
    if (test_rise && state_reg != rbs_pkg::ST_RESET && dev_reset_n_i)
    begin
      emu_next = debug_mode_select_i != rbs_pkg::EMU_SEL_BOUNDARY_SCAN_LOGIC;
      emu_lat_next = 1'b1;
    end
  end

  // Memory array, without reset.
  always_ff @(posedge core_clk_i)
  begin
    if (mem_we)
    begin
      mem[mem_widx] <= mem_wdata;
    end
  end

  // Registers of the fetch port and the test reset logic.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_reg <= 32'h0000_0000;
      tst_prev_reg <= 1'b0;
      tlr_reg <= 1'b1;
      emu_reg <= rbs_pkg::EMU_RST;
      emu_lat_reg <= 1'b0;
    end
    else
    begin
      fetch_reg <= fetch_next;
      tst_prev_reg <= tst_prev_next;
      tlr_reg <= tlr_next;
      emu_reg <= emu_next;
      emu_lat_reg <= emu_lat_next;
    end
  end

  // Output drive from registers.
  assign core_fetch_data_o = fetch_reg;
  assign core_stall_o = stall_reg;
  assign core_start_o = start_reg;
  assign core_start_addr_o = start_addr_reg;
  assign core_irq_o = irq_reg;
  assign periph_reset_o = periph_reg;
  assign host_port_en_o = hpi_reg;
  assign host_pci_en_o = pcien_reg;
  assign test_logic_reset_o = tlr_reg;
  assign emu_mode_o = emu_reg;
  assign variant_valid_o = variant_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking ast_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence hint_in_stall;
    state_reg == rbs_pkg::ST_HOST_STALL && hint_set && dev_reset_n_i;
  endsequence

  sequence core_released;
    core_start_o && !core_stall_o && core_start_addr_o == rbs_pkg::BOOT_ADDR;
  endsequence

  AST_RESET_HOLD: assert property (!dev_reset_n_i |=> periph_reset_o && core_stall_o)
    else $error("Device left reset while reset input was low.");
  AST_HOST_STALL: assert property (state_reg == rbs_pkg::ST_RESET && dev_reset_n_i
    && mode_reg == rbs_pkg::BOOT_HOST |=> core_stall_o && !periph_reset_o)
    else $error("Host boot did not stall the core with the device released.");
  AST_HOST_ROUTE: assert property (state_reg == rbs_pkg::ST_HOST_STALL
    |-> host_pci_en_o == pci_reg && host_port_en_o == !pci_reg)
    else $error("Host path does not follow the strap.");
  AST_HINT_RELEASE: assert property (hint_in_stall |=> core_released)
    else $error("Host flag did not release the core at the boot address.");
  AST_NO_IRQ_STALLED: assert property (core_irq_o |-> !$past(core_stall_o))
    else $error("Core interrupt raised while the core was stalled.");
  AST_ROM_STALL: assert property (state_reg == rbs_pkg::ST_ROM_COPY && dev_reset_n_i
    && !copy_done |=> core_stall_o && !core_start_o)
    else $error("Core released before the boot copy ended.");
  AST_HINT_BLOCK: assert property (core_irq_o |-> !$past(hint_reg, 1))
    else $error("Host flag accepted while still set.");
  AST_NOBOOT: assert property (state_reg == rbs_pkg::ST_RESET && dev_reset_n_i
    && mode_reg == rbs_pkg::BOOT_NONE |=> core_released)
    else $error("No-boot start did not run at once.");
  AST_EMU_LATCH: assert property (test_rise && state_reg != rbs_pkg::ST_RESET
    && dev_reset_n_i |=> emu_lat_reg
    && emu_mode_o == ($past(debug_mode_select_i) != rbs_pkg::EMU_SEL_BOUNDARY_SCAN_LOGIC))
    else $error("Debug mode select not latched on the test reset rise.");
  AST_STRAP_HOLD: assert property (state_reg != rbs_pkg::ST_RESET && dev_reset_n_i
    |=> $stable(mode_reg) && $stable(pci_reg))
    else $error("Boot straps changed after reset release.");

endmodule

`default_nettype wire

// ==== testbench/rbs_rom_model.sv ====
// Behavioural boot ROM that answers byte reads from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module rbs_rom_model (
  input wire logic rom_rd_i,
  input wire logic [31:0] rom_addr_i,
  output logic [7:0] rom_data_o
);
  logic [7:0] last_q = 8'h00;
  // Remembers the last byte so an idle bus shows its inverse, not a stale value.
  always @(rom_rd_i or rom_addr_i)
  begin
    if (rom_rd_i)
      last_q = rom_addr_i[7:0] ^ 8'h5A;
  end
  assign rom_data_o = rom_rd_i ? (rom_addr_i[7:0] ^ 8'h5A) : ~last_q;
endmodule
`default_nettype wire

// ==== testbench/rbs_sequencer_tb_top.sv ====
// Self-checking bench for the reset and boot sequencer.
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_tb_top;
  logic core_clk_i, rst_i, dev_reset_n_i, pci_boot_sel_i, big_endian_i, test_reset_n_i;
  logic core_hint_clr_i, avs_read_i, avs_write_i, rom_rd_o, core_stall_o, core_start_o;
  logic core_irq_o, periph_reset_o, host_port_en_o, host_pci_en_o, test_logic_reset_o;
  logic emu_mode_o, variant_valid_o, avs_waitrequest_o;
  logic [1:0] boot_mode_i, debug_mode_select_i;
  logic [4:0] avs_address_i;
  logic [7:0] core_fetch_addr_i, rom_data_i;
  logic [31:0] core_fetch_data_o, core_start_addr_o, avs_writedata_i, avs_readdata_o;
  logic [31:0] rom_addr_o, q;
  int err_total, cmp_count, starts, irqs, s0, i0;

  rbs_sequencer #(.MEM_WORDS(256), .COPY_BYTES(16)) DUT (.*);
  rbs_rom_model rom (.rom_rd_i(rom_rd_o), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));

  // The clock runs from time zero, before any reset release.
  initial
  begin
    core_clk_i = 1'h0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Counts start and core interrupt pulses as each edge samples them.
  always @(posedge core_clk_i)
  begin
    starts += (core_start_o === 1'h1);
    irqs += (core_irq_o === 1'h1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  end
  endtask

  task automatic report_and_stop;
  begin
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // One bus cycle, held until waitrequest is sampled low; read data lands in q.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
  begin
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    for (n = 0; n < 40; n++)
    begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'h0)
        break;
    end
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge core_clk_i);
    if (n == 40)
    begin
      err_total++;
      report_and_stop();
    end
  end
  endtask

  task automatic boot(input logic [1:0] m, input logic s, input logic e);
  begin
    dev_reset_n_i <= 1'h0;
    boot_mode_i <= m;
    pci_boot_sel_i <= s;
    big_endian_i <= e;
    repeat (4) @(posedge core_clk_i);
    s0 = starts;
    i0 = irqs;
    dev_reset_n_i <= 1'h1;
    repeat (4) @(posedge core_clk_i);
  end
  endtask

  task automatic clr;
  begin
    core_hint_clr_i <= 1'h1;
    @(posedge core_clk_i);
    core_hint_clr_i <= 1'h0;
    @(posedge core_clk_i);
  end
  endtask

  function automatic logic [7:0] rb(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // No boot and the unused code 3, with the test reset still held low.
  task automatic t_none;
  begin
    for (int m = 0; m < 4; m += 3)
    begin
      boot(m[1:0], 1'h0, 1'h0);
      chk(starts - s0, 32'h1);
      chk(core_stall_o, 32'h0);
      chk(core_start_addr_o, 32'h0);
      bus(1'h1, rbs_pkg::OFF_HPC, 32'h1);
      chk(starts - s0, 32'h1);
      clr();
    end
    $display("no boot test finished");
  end
  endtask

  task automatic t_host(input logic s);
  begin
    boot(2'h1, s, 1'h0);
    boot_mode_i <= 2'h2;
    chk(core_stall_o, 32'h1);
    chk(periph_reset_o, 32'h0);
    chk({host_pci_en_o, host_port_en_o}, s ? 32'h2 : 32'h1);
    bus(1'h0, rbs_pkg::OFF_STATUS, 32'h0);
    chk(q[5:0], {s, 2'h1, 1'h1, 2'h1});
    bus(1'h1, rbs_pkg::OFF_MEM_ADDR, 32'h5);
    bus(1'h1, rbs_pkg::OFF_MEM_DATA, 32'hC0DE0005);
    bus(1'h0, rbs_pkg::OFF_MEM_DATA, 32'h0);
    chk(q, 32'hC0DE0005);
    bus(1'h0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, rbs_pkg::OFF_HPC, 32'h1);
    chk(starts - s0, 32'h1);
    chk(core_stall_o, 32'h0);
    chk(irqs - i0, 32'h0);
    bus(1'h1, rbs_pkg::OFF_HPC, 32'h1);
    chk(irqs - i0, 32'h0);
    clr();
    bus(1'h1, rbs_pkg::OFF_HPC, 32'h1);
    chk(irqs - i0, 32'h1);
    clr();
    $display("host boot test finished");
  end
  endtask

  task automatic t_rom(input logic e);
    int n;
    logic [31:0] a;
  begin
    bus(1'h1, rbs_pkg::OFF_ROM_BASE, 32'h40);
    boot(2'h2, 1'h0, e);
    chk(rom_rd_o, 32'h1);
    chk(core_stall_o, 32'h1);
    for (n = 0; n < 400 && core_stall_o !== 1'h0; n++)
      @(posedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
    chk(n < 400, 32'h1);
    if (n == 400)
      report_and_stop();
    chk(starts - s0, 32'h1);
    for (int w = 0; w < 4; w++)
    begin
      core_fetch_addr_i <= w[7:0];
      repeat (2) @(posedge core_clk_i);
      a = 32'h40 + 4 * w;
      chk(core_fetch_data_o, e ? {rb(a), rb(a + 1), rb(a + 2), rb(a + 3)}
                               : {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)});
    end
    $display("memory boot test finished");
  end
  endtask

  // Debug select latch on test reset rise, and the variant flag.
  task automatic t_test;
  begin
    for (int k = 0; k < 2; k++)
    begin
      debug_mode_select_i <= k ? 2'h0 : 2'h2;
      test_reset_n_i <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      test_reset_n_i <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      chk(test_logic_reset_o, 32'h0);
      chk(emu_mode_o, k ? 32'h0 : 32'h1);
      chk(variant_valid_o, 32'h1);
      dev_reset_n_i <= 1'h0;
      repeat (3) @(posedge core_clk_i);
      chk(variant_valid_o, 32'h0);
      dev_reset_n_i <= 1'h1;
      repeat (3) @(posedge core_clk_i);
    end
    $display("test reset test finished");
  end
  endtask

  // All three resets asserted from time zero, then the scenarios in turn.
  initial
  begin
    {rst_i, test_reset_n_i, dev_reset_n_i} = 3'h4;
    {pci_boot_sel_i, big_endian_i, core_hint_clr_i, avs_read_i, avs_write_i} = 5'h0;
    {boot_mode_i, debug_mode_select_i, avs_address_i} = 9'h0;
    {core_fetch_addr_i, avs_writedata_i} = 40'h0;
    {err_total, cmp_count, starts, irqs} = {4{32'h0}};
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    chk(core_stall_o, 32'h1);
    chk(periph_reset_o, 32'h1);
    chk(test_logic_reset_o, 32'h1);
    t_none();
    t_host(1'h0);
    t_host(1'h1);
    t_rom(1'h1);
    t_rom(1'h0);
    t_test();
    report_and_stop();
  end
endmodule
`default_nettype wire
